// ---- logic/xram_decode_pkg.sv ----
// Package with register offsets, field layouts, reset values and types for the data-side address decoder.
package xram_decode_pkg;
	localparam logic [7:0]  PAGE_SEL_ADDR    = 8'hAA;
	localparam logic [7:0]  MEM_CFG_ADDR     = 8'h85;
	localparam logic [2:0]  PAGE_SEL_RESET   = 3'h0;
	localparam logic        FIFO_EN_RESET    = 1'h0;
	localparam logic [2:0]  WAIT_RESET       = 3'h0;
	localparam logic [7:0]  MEM_CFG_RO_BITS  = 8'h03;
	localparam int          FIFO_EN_BIT      = 6;
	localparam logic [7:0]  FIFO_WIN_PAGE    = 8'h04;
	localparam logic [7:0]  SFR_BASE         = 8'h80;
	localparam int          XRAM_AW          = 10;
	localparam logic [2:0]  FIFO_EXTRA_WAIT  = 3'h3;

	// One data-side request from the core.
	typedef struct packed {
		logic        valid;
		logic        wr;
		logic        ext;       // External-data move.
		logic        ext_wide;  // 16-bit pointer form.
		logic        direct;    // Direct addressing for internal space.
		logic        bit_op;    // Single-bit access.
		logic [15:0] addr;
		logic [7:0]  wdata;
	} core_req_s;

	// Routing decision for one request.
	typedef struct packed {
		logic       sel_iram;
		logic       sel_sfr;
		logic       sel_xram;
		logic       sel_fifo;
		logic       sfr_bit_ok;
		logic [9:0] xram_addr;
		logic [7:0] low_addr;
	} route_s;
endpackage : xram_decode_pkg

// ---- logic/xram_page_fifo_window_decode.sv ----
// Data-side address decoder with page select, FIFO window and register-space steering.
`timescale 1ns/1ns
// Contract
// RULE1: An 8-bit-operand external move takes its upper address byte from the page-select register.
// RULE2: Page select is a 3-bit read/write field in bits 2:0 resetting to zero, bits 7:3 read zero.
// RULE3: The page value picks a 256-byte page and the operand gives the byte within it.
// RULE4: With the FIFO enable bit set, FIFO RAM appears at external addresses 0x0400 to 0x04FF.
// RULE5: With the FIFO enable bit set, XRAM at 0x0400 to 0x04FF is unreachable.
// RULE6: With the FIFO enable bit clear there is no path to FIFO RAM, and the bit is read/write resetting to zero.
// RULE7: Software must have the USB clock at least twice the system clock before using the FIFO window.
// RULE8: External moves to the FIFO window are stretched by extra system-clock cycles.
// RULE9: Firmware should not move USB packet data through the window, but unused FIFO areas may be used as RAM.
// RULE10: In the memory configuration register bit 7 reads zero and bits 5:0 read 000011 and ignore writes.
// RULE11: Direct accesses at 0x80 to 0xFF go to the register space, not data RAM.
// RULE12: Registers at addresses with low nibble 0x0 or 0x8 allow bit access, others byte access only.
// RULE13: Software must not touch unoccupied register addresses.
// RULE14: With the window off, 16-bit external moves ignore the upper six address bits.
// RULE15: Indirect accesses above 0x7F reach the upper internal RAM, separate from registers.
// RULE16: With the window on, addresses outside it still reach XRAM with the same folding.
module xram_page_fifo_window_decode
(
	// Clock and reset.
	input  wire logic                       core_clk,
	input  wire logic                       rst_n,
	// Core request and stall.
	input  wire xram_decode_pkg::core_req_s req,
	output logic                            stall,
	// Register-space read path from this block.
	output logic [7:0]                      reg_rdata,
	output logic                            reg_hit,
	// Routing toward memories.
	output xram_decode_pkg::route_s         route,
	output logic                            fifo_window_enable
);
	import xram_decode_pkg::*;

	logic [2:0] page_select_ff;
	logic       fifo_en_ff;
	logic [2:0] wait_cnt_ff;
	logic [2:0] nxt_wait_cnt;
	logic [7:0] hi_byte;
	logic       in_window;
	logic       reg_space;

	// Bit-addressable register check, used only by the decoder for sfr_bit_ok; its check compares the low nibble itself.
	function automatic logic bit_addressable(input logic [7:0] a);
		bit_addressable = (a[2:0] == 3'h0);
	endfunction : bit_addressable

	// Upper byte of the external address from page or pointer.
	// Only page bits 1:0 survive the 10-bit XRAM fold; page 4 is the one that can open the window.
	always_comb
	begin
		hi_byte   = req.ext_wide ? req.addr[15:8] : {5'h00, page_select_ff}; // RULE1 RULE3
		in_window = fifo_en_ff && (hi_byte == FIFO_WIN_PAGE); // RULE4 RULE6
		reg_space = req.direct && !req.ext && (req.addr[7:0] >= SFR_BASE); // RULE11 RULE15
	end

	// Routing of each request.
	// The window test decides first, so a window hit never reaches the XRAM bytes behind it.
	always_comb
	begin
		route            = '0;
		route.low_addr   = req.addr[7:0]; // RULE3
		route.sel_sfr    = req.valid && reg_space; // RULE11
		route.sel_iram   = req.valid && !req.ext && !reg_space; // RULE15
		route.sel_fifo   = req.valid && req.ext && in_window; // RULE4 RULE6
		route.sel_xram   = req.valid && req.ext && !in_window; // RULE5 RULE16
		route.xram_addr  = {hi_byte[XRAM_AW-9:0], req.addr[7:0]}; // RULE14 RULE16
		route.sfr_bit_ok = reg_space && bit_addressable(req.addr[7:0]); // RULE12
	end

	// Every valid request lands in exactly one space, and the window and fold follow the page and pointer.
	route_onehot_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid |-> $onehot({route.sel_iram, route.sel_sfr, route.sel_xram, route.sel_fifo})) // RULE5 RULE11
		else $error("request routed to more or fewer than one space");
	ext_no_reg_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid && req.ext |-> !route.sel_sfr && !route.sel_iram && !reg_hit) // RULE11
		else $error("external move reached internal space");
	window_page_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid && req.ext && !req.ext_wide && fifo_en_ff && page_select_ff == 3'h4 |-> route.sel_fifo) // RULE4
		else $error("page four move missed the window");
	window_edge_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid && req.ext && req.ext_wide && req.addr[15:8] != 8'h04 |-> route.sel_xram && !route.sel_fifo) // RULE16
		else $error("move outside the window left XRAM");
	page_byte_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid && req.ext && !req.ext_wide && !route.sel_fifo |-> route.xram_addr[7:0] == req.addr[7:0]) // RULE3
		else $error("byte within page wrong");
	indirect_iram_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid && !req.ext && !req.direct |-> route.sel_iram && !reg_hit) // RULE15
		else $error("indirect access left internal RAM");
	bit_sfr_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		route.sfr_bit_ok |-> req.direct && !req.ext && req.addr[7]) // RULE12
		else $error("bit access flagged outside register space");

	// Page-select register: only bits 2:0 are stored.
	// Writes to bits 7:3 are dropped here, so those bits always read back as zero.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			page_select_ff <= PAGE_SEL_RESET;
		else if (route.sel_sfr && req.wr && req.addr[7:0] == PAGE_SEL_ADDR)
			page_select_ff <= req.wdata[2:0]; // RULE2
	end

	// A write to the page register shows on the next edge; anything else leaves it alone.
	page_write_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		route.sel_sfr && req.wr && req.addr[7:0] == 8'hAA |=> page_select_ff == $past(req.wdata[2:0])) // RULE2
		else $error("page write not stored");
	page_keep_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		!(route.sel_sfr && req.wr && req.addr[7:0] == 8'hAA) |=> $stable(page_select_ff)) // RULE2
		else $error("page changed without a write");

	// FIFO enable bit; other bits of the configuration register are fixed.
	// Reset leaves the window closed so that ordinary XRAM at 0x0400 stays reachable.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			fifo_en_ff <= FIFO_EN_RESET; // RULE6
		else if (route.sel_sfr && req.wr && req.addr[7:0] == MEM_CFG_ADDR)
			fifo_en_ff <= req.wdata[FIFO_EN_BIT]; // RULE6
	end

	// The enable bit follows writes to the configuration register and comes out of reset cleared.
	cfg_write_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		route.sel_sfr && req.wr && req.addr[7:0] == 8'h85 |=> fifo_en_ff == $past(req.wdata[6])) // RULE6
		else $error("enable write not stored");
	cfg_keep_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		!(route.sel_sfr && req.wr && req.addr[7:0] == 8'h85) |=> $stable(fifo_en_ff)) // RULE6
		else $error("enable changed without a write");
	fifo_reset_a : assert property (@(posedge core_clk) $rose(rst_n) |-> !fifo_en_ff && wait_cnt_ff == 3'h0) // RULE6
		else $error("window or stretch not cleared by reset");

	// Register read data.
	// Fixed configuration bits come from a constant, so no write can ever reach them.
	always_comb
	begin
		reg_rdata = 8'h00;
		reg_hit   = 1'b0;
		if (reg_space && req.addr[7:0] == PAGE_SEL_ADDR)
		begin
			reg_rdata = {5'h00, page_select_ff}; // RULE2
			reg_hit   = 1'b1;
		end
		else if (reg_space && req.addr[7:0] == MEM_CFG_ADDR)
		begin
			reg_rdata = MEM_CFG_RO_BITS | {1'b0, fifo_en_ff, 6'h00}; // RULE10
			reg_hit   = 1'b1;
		end
	end

	// Only the two local registers answer, and unused page bits stay zero.
	reg_hit_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_hit == (req.direct && !req.ext && (req.addr[7:0] == 8'hAA || req.addr[7:0] == 8'h85))) // RULE2 RULE10
		else $error("local register hit wrong");
	page_ro_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_hit && req.addr[7:0] == 8'hAA |-> reg_rdata[7:3] == 5'h00) // RULE2
		else $error("unused page bits not zero");

	// Wait counter stretches FIFO window moves across the clock crossing.
	// The stretch gives the FIFO RAM, which runs on the faster USB clock, time to answer.
	always_comb
	begin
		if (wait_cnt_ff != 3'h0)
			nxt_wait_cnt = wait_cnt_ff - 3'h1;
		else if (route.sel_fifo)
			nxt_wait_cnt = FIFO_EXTRA_WAIT; // RULE8
		else
			nxt_wait_cnt = 3'h0;
	end

	// Wait counter register.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			wait_cnt_ff <= WAIT_RESET;
		else
			wait_cnt_ff <= nxt_wait_cnt;
	end

	// Core holds the request while stalled; last cycle releases it.
	// A held window move reloads the count only once the counter has run empty.
	assign stall              = route.sel_fifo && (wait_cnt_ff != 3'h1); // RULE8
	assign fifo_window_enable = fifo_en_ff;

	// The stretch counter never exceeds its load, and a fresh window move is always held.
	wait_range_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		wait_cnt_ff <= FIFO_EXTRA_WAIT) // RULE8
		else $error("stretch counter out of range");
	stall_fifo_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		route.sel_fifo && wait_cnt_ff == 3'h0 |-> stall) // RULE8
		else $error("window move not stretched");

	// Reset value, page and fold, fixed bits, window map and stretch length.
	page_reset_a : assert property (@(posedge core_clk) $rose(rst_n) |-> page_select_ff == 3'h0) // RULE2
		else $error("page select not zero after reset");
	page_upper_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid && req.ext && !req.ext_wide && !in_window |-> route.xram_addr[9:8] == page_select_ff[1:0]) // RULE1
		else $error("page byte not used");
	cfg_read_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_space && req.addr[7:0] == 8'h85 |-> reg_rdata[5:0] == 6'h03 && !reg_rdata[7]) // RULE10
		else $error("config fixed bits wrong");
	no_fifo_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		!fifo_en_ff |-> !route.sel_fifo) // RULE6
		else $error("fifo reached while disabled");
	win_map_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid && req.ext && req.ext_wide && fifo_en_ff && req.addr[15:8] == 8'h04
		|-> route.sel_fifo && !route.sel_xram) // RULE4 RULE5
		else $error("window not mapped to fifo");
	fold_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid && req.ext && req.ext_wide && !route.sel_fifo |-> route.xram_addr == req.addr[9:0]) // RULE14 RULE16
		else $error("xram folding wrong");
	sfr_route_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.valid && !req.ext && req.addr[7] |-> route.sel_sfr == req.direct && route.sel_iram == !req.direct) // RULE11 RULE15
		else $error("upper internal routing wrong");
	bit_addr_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		req.direct && !req.ext && req.addr[7]
		|-> route.sfr_bit_ok == (req.addr[3:0] == 4'h0 || req.addr[3:0] == 4'h8)) // RULE12
		else $error("bit-addressable decode wrong");
	fifo_stall_a : assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(route.sel_fifo) && wait_cnt_ff == 3'h0 |-> stall [*3] ##1 !stall) // RULE8
		else $error("fifo stretch length wrong");
endmodule : xram_page_fifo_window_decode

// ---- sim/core_model.sv ----
// Core-side model that issues data requests and holds them through a stall.
`timescale 1ns/1ns
module core_model
(
	// Clock and stall.
	input  wire logic                  core_clk,
	input  wire logic                  stall,
	// Request toward the decoder.
	output xram_decode_pkg::core_req_s req
);
	import xram_decode_pkg::*;
	// Nothing is requested before the first issue.
	initial req = '0;
	// Launches one request after an edge and holds it until stall drops; w counts the stretch.
	task automatic issue(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d, output int w);
		w = 0;
		@(posedge core_clk);
		// Window moves are issued only on the premise that the USB clock already runs at twice the system clock.
		req <= {1'b1, k, 1'b0, a, d};
		#1;
		while (stall === 1'b1 && w < 9)
		begin
			@(posedge core_clk);
			w++;
			#1;
		end
	endtask : issue
endmodule : core_model

// ---- sim/testbench.sv ----
// Self-checking bench for the data-side address decoder.
`timescale 1ns/1ns
module testbench;
	import xram_decode_pkg::*;
	logic       core_clk;
	logic       rst_n;
	core_req_s  req;
	logic       stall;
	logic [7:0] reg_rdata;
	logic       reg_hit;
	route_s     route;
	logic       fifo_window_enable;
	int         fails;
	int         num_checks;
	int         w;
	// Free-running system clock.
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	core_model i_core_model (.core_clk(core_clk), .stall(stall), .req(req));
	xram_page_fifo_window_decode i_xram_page_fifo_window_decode (.core_clk(core_clk), .rst_n(rst_n), .req(req),
		.stall(stall), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .route(route),
		.fifo_window_enable(fifo_window_enable));
	// Compares one value and counts it.
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict
	// Direct register write and read at the local register addresses.
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		i_core_model.issue(4'b1001, {8'h00, a}, d, w);
	endtask : wreg
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		i_core_model.issue(4'b0001, {8'h00, a}, 8'h00, w);
		chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
		chk("reg_hit", 16'h0001, {15'h0000, reg_hit});
	endtask : rreg
	// One access; s is iram, sfr, xram, fifo, bit-ok; x the folded address; n the stretch.
	task automatic acc(input logic [3:0] k, input logic [15:0] a, input logic [4:0] s, input logic [9:0] x, input int n);
		logic [3:0] seen;
		i_core_model.issue(k, a, 8'h00, w);
		seen = {route.sel_iram, route.sel_sfr, route.sel_xram, route.sel_fifo};
		chk("route_sel", {12'h000, s[4:1]}, {12'h000, seen});
		chk("low_addr", {8'h00, a[7:0]}, {8'h00, route.low_addr});
		chk("reg_hit", 16'h0000, {15'h0000, reg_hit});
		if (s[3])
			chk("sfr_bit_ok", {15'h0000, s[0]}, {15'h0000, route.sfr_bit_ok});
		if (s[2])
			chk("xram_addr", {6'h00, x}, {6'h00, route.xram_addr});
		chk("stall_cycles", 16'(n), 16'(w));
	endtask : acc
	// Main sequence; only occupied register addresses are used.
	initial
	begin
		rst_n = 1'b0;
		fails = 0;
		num_checks = 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rreg(8'hAA, 8'h00);
		rreg(8'h85, 8'h03);
		chk("fifo_en", 16'h0000, {15'h0000, fifo_window_enable});
		wreg(8'hAA, 8'hFD);
		rreg(8'hAA, 8'h05);
		acc(4'b0100, 16'h0034, 5'b00100, 10'h134, 0);
		wreg(8'hAA, 8'h04);
		acc(4'b0100, 16'hFF12, 5'b00100, 10'h012, 0);
		acc(4'b0110, 16'h0412, 5'b00100, 10'h012, 0);
		wreg(8'h85, 8'hFF);
		rreg(8'h85, 8'h43);
		chk("fifo_en", 16'h0001, {15'h0000, fifo_window_enable});
		acc(4'b0100, 16'h0012, 5'b00010, 10'h000, 3);
		acc(4'b0110, 16'h1C12, 5'b00100, 10'h012, 0);
		acc(4'b0110, 16'h04FF, 5'b00010, 10'h000, 3);
		wreg(8'h85, 8'h00);
		acc(4'b0110, 16'h04FF, 5'b00100, 10'h0FF, 0);
		acc(4'b0001, 16'h0088, 5'b01001, 10'h000, 0);
		acc(4'b0001, 16'h0089, 5'b01000, 10'h000, 0);
		acc(4'b0000, 16'h0088, 5'b10000, 10'h000, 0);
		// Mid-run reset with the window open and page 4 set; a read stands on the bus so no write repeats.
		wreg(8'h85, 8'h40);
		rreg(8'h85, 8'h43);
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rreg(8'hAA, 8'h00);
		rreg(8'h85, 8'h03);
		chk("fifo_en", 16'h0000, {15'h0000, fifo_window_enable});
		print_verdict();
	end
	// Cuts the run short if the sequence hangs.
	initial
	begin
		#5000;
		fails++;
		print_verdict();
	end
endmodule : testbench
